/* File: hw/ext_mem_pkg.sv */
// External memory port: register map, field layout and shared types.
// Assumes a single 10 MHz core clock and a word-wide register port.
package ext_mem_pkg;

   // Core clock and structure
   localparam int CLK_HZ      = 10_000_000;
   localparam int MAX_SPACES  = 4;
   localparam int SPACE_W     = 2;
   localparam int CNT_W       = 4;
   localparam int ADDR_W      = 20;
   localparam int DATA_W      = 32;
   localparam int BE_W        = 4;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL       = 8'h00;
   localparam logic [7:0] OFS_STATUS     = 8'h04;
   localparam logic [7:0] OFS_ADDR       = 8'h08;
   localparam logic [7:0] OFS_WDATA      = 8'h0c;
   localparam logic [7:0] OFS_CMD        = 8'h10;
   localparam logic [7:0] OFS_RDATA      = 8'h14;
   localparam logic [7:0] OFS_SPACE_BASE = 8'h20;
   localparam logic [7:0] SPACE_STRIDE   = 8'h10;
   localparam logic [7:0] OFS_TIMING     = 8'h00;
   localparam logic [7:0] OFS_SC_A       = 8'h04;
   localparam logic [7:0] OFS_SC_B       = 8'h08;

   // Async timing register fields (4 bits each)
   localparam int F_RD_SETUP  = 0;
   localparam int F_RD_STROBE = 4;
   localparam int F_RD_HOLD   = 8;
   localparam int F_WR_SETUP  = 12;
   localparam int F_WR_STROBE = 16;
   localparam int F_WR_HOLD   = 20;
   localparam logic [23:0] TIMING_RST = 24'h131131;

   // Secondary control a: latencies and clock select
   localparam int F_RD_LAT    = 0;
   localparam int F_WR_LAT    = 2;
   localparam int F_CLK_SEL   = 4;
   localparam logic [4:0] SC_A_RST = 5'h00;

   // Secondary control b: extension, fifo mode, sync enable
   localparam int F_EXTEND    = 0;
   localparam int F_FIFO_MODE = 1;
   localparam int F_SYNC_EN   = 2;
   localparam logic [2:0] SC_B_RST = 3'h0;

   // Control and command fields
   localparam int F_DIV_B     = 0;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int F_CMD_READ  = 0;
   localparam int F_CMD_SPACE = 4;
   localparam int F_CMD_BE    = 8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_A_SETUP, ST_A_STROBE, ST_A_HOLD,
      ST_S_WAIT, ST_S_DESEL
   } state_type;

   // Memory side pins, all strobes active low
   typedef struct packed {
      logic              sel_n;
      logic [BE_W-1:0]   be_n;
      logic [ADDR_W-1:0] addr;
      logic              oe_n;
      logic              stb_n;
      logic              we_n;
      logic              dq_oe_n;
      logic [DATA_W-1:0] dq;
   } pins_type;

   localparam pins_type PINS_IDLE = '{1'b1, 4'hf, 20'h00000, 1'b1, 1'b1,
                                      1'b1, 1'b1, 32'h00000000};

endpackage

/* File: hw/ext_mem_port.sv */
// External memory port: sequences async and programmable sync accesses.
// Assumes software starts one access at a time through the command
// register and polls busy; memory clocks are made here from clock_i.
//
// Behaviour
// - async strobes change only on clock A rise
// - read selects valid for read setup periods
// - read selects held for read hold periods
// - write selects get setup and hold periods
// - selects are enable, lanes, address, oe, data
// - six async counts kept per space
// - ready synchronised, acted on when sampled
// - async read data taken at strobe rise
// - sync read latency zero to three
// - sync write latency zero to three
// - extension clear, enable drops after command
// - extension set, on reads enable follows output enable
// - fifo mode clear, address strobe, deselects
// - fifo mode set, read enable, no deselects
// - per-space choice of clock A or B
// - sync pins change on selected clock rise
// - sync read data sampled on selected rise
// - async use of shared pins oe, rd, wr
// - sync use of shared pins ads, oe, we
// - sync settings in two registers per space
// - clock B is input clock over 2,4,8
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module ext_mem_port
   import ext_mem_pkg::*;
#(
   parameter int SPACES = MAX_SPACES
)
(
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   input  wire logic [7:0]          reg_addr_i,
   input  wire logic [31:0]         reg_wdata_i,
   input  wire logic                reg_we_i,
   input  wire logic                reg_re_i,
   output logic      [31:0]         reg_rdata_o,
   output logic                     busy_o,
   output logic                     mem_clock_out_a_o,
   output logic                     mem_clock_out_b_o,
   output logic      [SPACES-1:0]   space_select_n_o,
   output logic      [BE_W-1:0]     byte_lane_enables_n_o,
   output logic      [ADDR_W-1:0]   mem_word_address_o,
   output logic                     oe_pin_n_o,
   output logic                     strobe_pin_n_o,
   output logic                     write_pin_n_o,
   output logic      [DATA_W-1:0]   mem_data_bus_o,
   output logic                     mem_data_bus_oe_n_o,
   input  wire logic [DATA_W-1:0]   mem_data_bus_i,
   input  wire logic                async_ready_in_i
);

   // Elaboration guard: the register map holds four spaces at most
   if (SPACES < 1 || SPACES > MAX_SPACES)
   begin : g_bad_spaces
      $error("ext_mem_port: SPACES must be 1 to 4");
   end

   logic [1:0]        ctrl_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [DATA_W-1:0] rdata_r;
   logic [31:0]       reg_rdata_r;
   logic [23:0]       tim_r  [SPACES];
   logic [4:0]        sca_r  [SPACES];
   logic [2:0]        scb_r  [SPACES];
   logic              clk_a_r;
   logic              clk_b_r;
   logic [2:0]        div_b_r;
   logic              rdy_s1_r;
   logic              rdy_s2_r;
   logic              rdy_s3_r;
   logic              rdy_lvl_r;
   state_type         state_r;
   pins_type          pins_r;
   logic [SPACES-1:0] sel_n_r;
   logic [CNT_W-1:0]  cnt_r;
   logic              rd_r;
   logic [SPACE_W-1:0] sp_r;
   logic              busy_r;
   logic [BE_W-1:0]   be_r;

   // Register port decode
   wire logic [31:0]  cmd_w     = reg_wdata_i;
   wire logic [SPACE_W-1:0] cmd_sp = cmd_w[F_CMD_SPACE +: SPACE_W];
   wire logic         wr_ctrl   = reg_we_i && reg_addr_i == OFS_CTRL;
   wire logic         wr_addr   = reg_we_i && reg_addr_i == OFS_ADDR;
   wire logic         wr_wdata  = reg_we_i && reg_addr_i == OFS_WDATA;
   // A command while busy or to a missing space is dropped
   wire logic         go        = reg_we_i && reg_addr_i == OFS_CMD &&
                                  !busy_r && (32'(cmd_sp) < SPACES);
   wire logic         in_space  = reg_addr_i >= OFS_SPACE_BASE &&
                                  reg_addr_i < 8'(OFS_SPACE_BASE +
                                  8'(SPACES) * SPACE_STRIDE);
   wire logic [7:0]   sp_rel    = reg_addr_i - OFS_SPACE_BASE;
   wire logic [SPACE_W-1:0] rd_sp = sp_rel[4 +: SPACE_W];
   wire logic [7:0]   sub_ofs   = {4'h0, sp_rel[3:0]};

   // Settings of the space being accessed
   wire logic [23:0]  tim       = tim_r[sp_r];
   wire logic [1:0]   rd_lat    = sca_r[sp_r][F_RD_LAT +: 2];
   wire logic [1:0]   wr_lat    = sca_r[sp_r][F_WR_LAT +: 2];
   wire logic         clk_sel   = sca_r[sp_r][F_CLK_SEL];
   wire logic         extend    = scb_r[sp_r][F_EXTEND];
   wire logic         fifo_mode = scb_r[sp_r][F_FIFO_MODE];
   wire logic         sync_en   = scb_r[sp_r][F_SYNC_EN];
   wire logic [3:0]   setup_cnt = rd_r ? tim[F_RD_SETUP +: 4]
                                       : tim[F_WR_SETUP +: 4];
   wire logic [3:0]   strobe_cnt = rd_r ? tim[F_RD_STROBE +: 4]
                                        : tim[F_WR_STROBE +: 4];
   wire logic [3:0]   hold_cnt  = rd_r ? tim[F_RD_HOLD +: 4]
                                       : tim[F_WR_HOLD +: 4];

   // Clock ticks: a tick marks the core cycle ending in a rising edge.
   // Clock B is picked from a free phase count; the slower rates use the
   // count plus two so that every B rise lands on an A rise.
   wire logic         tick_a    = !clk_a_r;
   wire logic [1:0]   div_code  = ctrl_r[F_DIV_B +: 2];
   wire logic [2:0]   div_b_nxt = div_b_r + 3'h1;
   wire logic [2:0]   div_b_ofs = div_b_r + 3'h2;
   wire logic         b_pick    = div_code == 2'h1 ? div_b_ofs[1]
                                : div_code == 2'h2 ? div_b_ofs[2]
                                : div_b_nxt[0];
   // A divide code changed mid-period may not raise B off an A rise
   wire logic         clk_b_nxt = b_pick && (tick_a || clk_b_r);
   wire logic         tick_b    = clk_b_nxt && !clk_b_r;
   wire logic         tick_s    = clk_sel ? tick_b : tick_a;
   wire logic         tick      = sync_en ? tick_s : tick_a;

   // Sync edge count since the command, one past the latency ends it
   wire logic [CNT_W-1:0] edge_no = cnt_r + 4'h1;
   wire logic [CNT_W-1:0] lat_end = rd_r ? {2'h0, rd_lat} + 4'h1
                                         : {2'h0, wr_lat} + 4'h1;

   // Shared enable edges, so each space select moves on the same tick
   wire logic         sel_set   = tick && state_r == ST_START;
   wire logic         sel_clr   = tick && (state_r == ST_S_DESEL ||
                                  (state_r == ST_A_HOLD && cnt_r <= 4'h1) ||
                                  (state_r == ST_S_WAIT &&
                                   (!(extend && rd_r) || edge_no == lat_end)));

   // Read mux for the register port
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (in_space)
      begin
         unique case (sub_ofs)
            OFS_TIMING: rd_mux = {8'h00, tim_r[rd_sp]};
            OFS_SC_A:   rd_mux = {27'h0, sca_r[rd_sp]};
            OFS_SC_B:   rd_mux = {29'h0, scb_r[rd_sp]};
            default:    rd_mux = 32'h00000000;
         endcase
      end
      else
      begin
         unique case (reg_addr_i)
            OFS_CTRL:   rd_mux = {30'h0, ctrl_r};
            OFS_STATUS: rd_mux = {30'h0, rdy_lvl_r, busy_r};
            OFS_ADDR:   rd_mux = {12'h000, addr_r};
            OFS_WDATA:  rd_mux = wdata_r;
            OFS_RDATA:  rd_mux = rdata_r;
            default:    rd_mux = 32'h00000000;
         endcase
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         reg_rdata_r <= 32'h00000000;
      else
         reg_rdata_r <= reg_re_i ? rd_mux : 32'h00000000;
   end

   // Global registers: clock B divider, address and write data
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_r  <= CTRL_RST;
         addr_r  <= 20'h00000;
         wdata_r <= 32'h00000000;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_r <= reg_wdata_i[F_DIV_B +: 2];
         if (wr_addr)
            addr_r <= reg_wdata_i[ADDR_W-1:0];
         if (wr_wdata)
            wdata_r <= reg_wdata_i;
      end
   end

   // Per-space timing and secondary control registers
   for (genvar k = 0; k < SPACES; k++)
   begin : g_space
      localparam logic [7:0] BASE = 8'(OFS_SPACE_BASE + 8'(k) * SPACE_STRIDE);
      wire logic wr_tim = reg_we_i && reg_addr_i == BASE + OFS_TIMING;
      wire logic wr_sca = reg_we_i && reg_addr_i == BASE + OFS_SC_A;
      wire logic wr_scb = reg_we_i && reg_addr_i == BASE + OFS_SC_B;
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
         if (!nrst_i)
         begin
            tim_r[k] <= TIMING_RST;
            sca_r[k] <= SC_A_RST;
            scb_r[k] <= SC_B_RST;
         end
         else
         begin
            if (wr_tim)
               tim_r[k] <= reg_wdata_i[23:0];
            if (wr_sca)
               sca_r[k] <= reg_wdata_i[4:0];
            if (wr_scb)
               scb_r[k] <= reg_wdata_i[2:0];
         end
      end
   end

   // Clock A runs at half the core rate; clock B divides it by 1, 2, 4
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         clk_a_r <= 1'b0;
         clk_b_r <= 1'b0;
         div_b_r <= 3'h0;
      end
      else
      begin
         clk_a_r <= !clk_a_r;
         div_b_r <= div_b_nxt;
         clk_b_r <= clk_b_nxt;
      end
   end

   // Ready synchroniser; a level counts once stages two and three agree.
   // The extra stage adds latency, so ready must stand about two periods.
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rdy_s1_r  <= 1'b1;
         rdy_s2_r  <= 1'b1;
         rdy_s3_r  <= 1'b1;
         rdy_lvl_r <= 1'b1;
      end
      else
      begin
         rdy_s1_r <= async_ready_in_i;
         rdy_s2_r <= rdy_s1_r;
         rdy_s3_r <= rdy_s2_r;
         if (rdy_s2_r == rdy_s3_r)
            rdy_lvl_r <= rdy_s3_r;
      end
   end

   // Access sequencer; pins move only on the tick of the active clock
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r <= ST_IDLE;
         pins_r  <= PINS_IDLE;
         cnt_r   <= 4'h0;
         rd_r    <= 1'b0;
         sp_r    <= 2'h0;
         be_r    <= 4'hf;
         rdata_r <= 32'h00000000;
         busy_r  <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
               if (go)
               begin
                  state_r     <= ST_START;
                  busy_r      <= 1'b1;
                  rd_r        <= cmd_w[F_CMD_READ];
                  sp_r        <= cmd_sp;
                  be_r        <= ~cmd_w[F_CMD_BE +: BE_W];
               end
            ST_START:
               if (tick && !sync_en)
               begin
                  // Async: selects go valid, setup count begins
                  pins_r.sel_n   <= 1'b0;
                  pins_r.addr    <= addr_r;
                  pins_r.be_n    <= be_r;
                  pins_r.oe_n    <= !rd_r;
                  pins_r.dq      <= wdata_r;
                  pins_r.dq_oe_n <= rd_r;
                  cnt_r          <= setup_cnt;
                  state_r        <= ST_A_SETUP;
               end
               else if (tick && sync_en)
               begin
                  // Sync: command edge, latency counts from here
                  pins_r.sel_n   <= 1'b0;
                  pins_r.addr    <= addr_r;
                  pins_r.stb_n   <= fifo_mode && !rd_r;
                  pins_r.be_n    <= be_r;
                  pins_r.oe_n    <= !rd_r;
                  pins_r.we_n    <= rd_r;
                  pins_r.dq      <= wdata_r;
                  pins_r.dq_oe_n <= rd_r || wr_lat != 2'h0;
                  cnt_r          <= 4'h0;
                  state_r        <= ST_S_WAIT;
               end
            ST_A_SETUP:
               if (tick)
               begin
                  if (cnt_r <= 4'h1)
                  begin
                     // Strobe falls after the setup periods
                     pins_r.stb_n <= !rd_r;
                     pins_r.we_n  <= rd_r;
                     cnt_r        <= strobe_cnt;
                     state_r      <= ST_A_STROBE;
                  end
                  else
                     cnt_r <= cnt_r - 4'h1;
               end
            ST_A_STROBE:
               if (tick)
               begin
                  if (cnt_r > 4'h1)
                     cnt_r <= cnt_r - 4'h1;
                  else if (rdy_lvl_r)
                  begin
                     // Strobe rises; read data caught on this same edge
                     pins_r.stb_n <= 1'b1;
                     pins_r.we_n  <= 1'b1;
                     if (rd_r)
                        rdata_r <= mem_data_bus_i;
                     cnt_r        <= hold_cnt;
                     state_r      <= ST_A_HOLD;
                  end
               end
            ST_A_HOLD:
               if (tick)
               begin
                  if (cnt_r <= 4'h1)
                  begin
                     pins_r  <= PINS_IDLE;
                     busy_r  <= 1'b0;
                     state_r <= ST_IDLE;
                  end
                  else
                     cnt_r <= cnt_r - 4'h1;
               end
            ST_S_WAIT:
               if (tick)
               begin
                  cnt_r        <= edge_no;
                  // Command lasts one edge of the selected clock
                  pins_r.stb_n <= 1'b1;
                  pins_r.we_n  <= 1'b1;
                  if (!(extend && rd_r))
                     pins_r.sel_n <= 1'b1;
                  if (!rd_r && edge_no == {2'h0, wr_lat})
                     pins_r.dq_oe_n <= 1'b0;
                  if (edge_no == lat_end)
                  begin
                     if (rd_r)
                        rdata_r <= mem_data_bus_i;
                     // Output enable drops; on extended reads enable drops with it
                     pins_r.sel_n   <= 1'b1;
                     pins_r.oe_n    <= 1'b1;
                     pins_r.dq_oe_n <= 1'b1;
                     if (fifo_mode)
                     begin
                        busy_r  <= 1'b0;
                        state_r <= ST_IDLE;
                     end
                     else
                        state_r <= ST_S_DESEL;
                  end
               end
            ST_S_DESEL:
               if (tick)
               begin
                  // One idle edge with enable, oe and data released, lanes and address still driven
                  pins_r  <= PINS_IDLE;
                  busy_r  <= 1'b0;
                  state_r <= ST_IDLE;
               end
            default:
            begin
               pins_r  <= PINS_IDLE;
               busy_r  <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // One-hot space select, moving on the same tick as the shared enable
   for (genvar s = 0; s < SPACES; s++)
   begin : g_sel
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
         if (!nrst_i)
            sel_n_r[s] <= 1'b1;
         else if (sel_set && 32'(sp_r) == s)
            sel_n_r[s] <= 1'b0;
         else if (sel_clr)
            sel_n_r[s] <= 1'b1;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_o           = reg_rdata_r;
   assign busy_o                = busy_r;
   assign mem_clock_out_a_o     = clk_a_r;
   assign mem_clock_out_b_o     = clk_b_r;
   assign space_select_n_o      = sel_n_r;
   assign byte_lane_enables_n_o = pins_r.be_n;
   assign mem_word_address_o    = pins_r.addr;
   assign oe_pin_n_o            = pins_r.oe_n;
   assign strobe_pin_n_o        = pins_r.stb_n;
   assign write_pin_n_o         = pins_r.we_n;
   assign mem_data_bus_o        = pins_r.dq;
   assign mem_data_bus_oe_n_o   = pins_r.dq_oe_n;

endmodule

/* File: tb/ext_mem_props.sv */
// Checker: pin timing relations of the memory port.
// Assumes a bind onto ext_mem_port; sees only its ports.
`timescale 1ns/1ps
module ext_mem_props
#(
   parameter int SPACES = 4
)
(
   input wire logic              clock_i,
   input wire logic              nrst_i,
   input wire logic              reg_re_i,
   input wire logic [31:0]       reg_rdata_o,
   input wire logic              busy_o,
   input wire logic              mem_clock_out_a_o,
   input wire logic              mem_clock_out_b_o,
   input wire logic [SPACES-1:0] space_select_n_o,
   input wire logic [3:0]        byte_lane_enables_n_o,
   input wire logic [19:0]       mem_word_address_o,
   input wire logic              oe_pin_n_o,
   input wire logic              strobe_pin_n_o,
   input wire logic              write_pin_n_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // Pins move only with a clock A rise, so memories see clean edges
   a_strobe_on_rise: assert property ($changed(strobe_pin_n_o) |->
      $rose(mem_clock_out_a_o)) else $error("strobe moved off clock A");
   a_write_on_rise: assert property ($changed(write_pin_n_o) |->
      $rose(mem_clock_out_a_o)) else $error("write moved off clock A");
   a_oe_on_rise: assert property ($changed(oe_pin_n_o) |->
      $rose(mem_clock_out_a_o)) else $error("oe moved off clock A");
   a_addr_on_rise: assert property ($changed(mem_word_address_o) |->
      $rose(mem_clock_out_a_o)) else $error("address moved off clock A");
   a_clka_toggles: assert property ($past(nrst_i) |->
      mem_clock_out_a_o != $past(mem_clock_out_a_o))
      else $error("clock A stalled");
   a_b_on_a_rise: assert property ($rose(mem_clock_out_b_o) |->
      $rose(mem_clock_out_a_o)) else $error("clock B rose off clock A");
   a_lanes_on_rise: assert property (
      $changed(byte_lane_enables_n_o) |-> $rose(mem_clock_out_a_o))
      else $error("lanes moved off clock A");
   a_select_at_strobe: assert property ($fell(strobe_pin_n_o) |=>
      !(&space_select_n_o)) else $error("strobe without select");
   a_strobe_in_busy: assert property (!strobe_pin_n_o |-> busy_o)
      else $error("strobe low while idle");
   a_write_in_busy: assert property (!write_pin_n_o |-> busy_o)
      else $error("write low while idle");
   a_rdata_one_cycle: assert property (!$past(reg_re_i) |->
      reg_rdata_o == 32'h0) else $error("read data outside its cycle");
   c_read: cover property ($fell(strobe_pin_n_o));
   c_write: cover property ($fell(write_pin_n_o));
   c_busy: cover property ($fell(busy_o));
endmodule
bind ext_mem_port ext_mem_props #(.SPACES(SPACES)) i_ext_mem_props (.*);

/* File: tb/mem_model.sv */
// Behavioural memory behind the port: 16 words, optional slow ready.
// Assumes selects are stable while the data output enable is low.
`timescale 1ns/1ps
module mem_model
(
   input  wire logic        clock_i,
   input  wire logic        stall_i,
   input  wire logic [19:0] addr_i,
   input  wire logic        oe_n_i,
   input  wire logic        stb_n_i,
   input  wire logic        dq_oe_n_i,
   input  wire logic [31:0] dq_i,
   output logic      [31:0] dq_o,
   output logic             ready_o
);
   logic [31:0] mem [16];
   logic [31:0] last_r = 32'h0;
   int          low_r  = 0;
   // Released bus shows the inverse, never a stale copy
   assign dq_o = !oe_n_i ? mem[addr_i[3:0]] : ~last_r;
   // Ready held low 8 cycles, well over two clock A periods
   assign ready_o = !(stall_i && low_r > 0 && low_r < 9);
   // Store whatever the device drives; reads latch last value
   always @(posedge clock_i)
   begin
      if (!dq_oe_n_i) mem[addr_i[3:0]] <= dq_i;
      if (!oe_n_i) last_r <= dq_o;
      low_r <= stb_n_i ? 0 : low_r + 1;
   end
endmodule

/* File: tb/tb_top.sv */
// Testbench: register checks, async and sync accesses with counts.
// Assumes one access at a time, polled through busy.
`timescale 1ns/1ps
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin fail_count++; \
 $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   import ext_mem_pkg::*;
   logic        clock_i = 0, nrst_i = 0, reg_we_i = 0, reg_re_i = 0, stall = 0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, rd_v, d, dq_o, rdata;
   logic        busy, oe_n, stb_n, we_n, dq_oe_n, rdy, ckb;
   logic [3:0]  sel_n, be_n;
   logic [19:0] addr, a;
   logic [31:0] dq_i;
   logic [3:0]  rs, st, rh, ws, wt, wh;
   int          fail_count = 0, checks = 0, cyc = 0, t;
   int          n_sel = 0, n_oe = 0, n_stb = 0, n_we = 0;
   ext_mem_port i_ext_mem_port (.clock_i(clock_i), .nrst_i(nrst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(rdata),
      .busy_o(busy), .mem_clock_out_a_o(), .mem_clock_out_b_o(ckb),
      .space_select_n_o(sel_n), .byte_lane_enables_n_o(be_n),
      .mem_word_address_o(addr), .oe_pin_n_o(oe_n), .strobe_pin_n_o(stb_n),
      .write_pin_n_o(we_n), .mem_data_bus_o(dq_i),
      .mem_data_bus_oe_n_o(dq_oe_n), .mem_data_bus_i(dq_o),
      .async_ready_in_i(rdy));
   mem_model i_mem_model (.clock_i(clock_i), .stall_i(stall), .addr_i(addr),
      .oe_n_i(oe_n), .stb_n_i(stb_n), .dq_oe_n_i(dq_oe_n), .dq_i(dq_i),
      .dq_o(dq_o), .ready_o(rdy));
   always #50 clock_i = ~clock_i;
   // Low-time counters, cleared before each command
   always @(posedge clock_i)
   begin
      cyc++;
      n_sel <= n_sel + int'(!(&sel_n));
      n_oe <= n_oe + int'(!oe_n);
      n_stb <= n_stb + int'(!stb_n);
      n_we <= n_we + int'(!we_n);
      if (cyc == 40000)
      begin
         fail_count++;
         stop_test;
      end
   end
   task stop_test;
      if (fail_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // A gap cycle after each strobe keeps drivers single per step
   task wr(input logic [7:0] ad, input logic [31:0] v);
      reg_addr_i <= ad; reg_wdata_i <= v; reg_we_i <= 1'b1;
      @(posedge clock_i);
      reg_we_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task rd(input logic [7:0] ad, output logic [31:0] v);
      reg_addr_i <= ad; reg_re_i <= 1'b1;
      @(posedge clock_i);
      reg_re_i <= 1'b0;
      #1 v = rdata;
      @(posedge clock_i);
   endtask
   task acc(input logic [1:0] sp, input logic r);
      wr(8'h08, {12'h0, a});
      wr(8'h0c, d);
      #1 {n_sel, n_oe, n_stb, n_we} = '0;
      wr(8'h10, {20'h0, 4'hf, 2'b00, sp, 3'b000, r});
      t = 0;
      while ((busy || t < 3) && t < 400)
      begin
         @(posedge clock_i);
         #1 t++;
      end
      if (t == 400) fail_count++;
      if (r) rd(8'h14, rd_v);
   endtask
   function automatic logic [3:0] rnd3();
      return 4'($urandom_range(1, 3));
   endfunction
   initial
   begin
      void'($urandom(5735));
      repeat (12) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      rd(8'h20, rd_v); `CHK(rd_v, 32'h00131131)
      rd(8'h34, rd_v); `CHK(rd_v, 32'h0)
      wr(8'h80, 32'hffffffff); rd(8'h80, rd_v); `CHK(rd_v, 32'h0)
      // Async: random counts, strobe and select widths in core cycles
      for (int i = 0; i < 7; i++)
      begin
         {rs, st, rh} = {rnd3(), rnd3(), rnd3()};
         {ws, wt, wh} = {rnd3(), rnd3(), rnd3()};
         // A stall only shows once the strobe outlasts the synchroniser
         if (i == 6) st = 4'h3;
         wr(8'h20, {8'h0, wh, wt, ws, rh, st, rs});
         rd(8'h20, rd_v); `CHK(rd_v, {8'h0, wh, wt, ws, rh, st, rs})
         a = 20'($urandom_range(0, 15)); d = $urandom;
         acc(2'd0, 1'b0);
         `CHK(n_we, 2 * wt)
         `CHK(n_sel, 2 * (ws + wt + wh))
         stall = (i == 6);
         acc(2'd0, 1'b1);
         `CHK(rd_v, d)
         `CHK(n_oe - n_stb, 2 * (rs + rh))
         if (i == 6) `CHK(n_stb > 2 * st, 1'b1)
         else `CHK(n_stb, 2 * st)
         stall = 0;
      end
      // Sync on clock A: every latency with each extend and fifo mode
      for (int k = 0; k < 16; k++)
      begin
         wr(8'h34, {27'h0, 1'b0, 2'(k % 4), 2'(k % 4)});
         wr(8'h38, {29'h0, 1'b1, 1'(k / 8), 1'(k / 4)});
         a = 20'($urandom_range(0, 15)); d = $urandom;
         acc(2'd1, 1'b0);
         `CHK(n_stb, (k / 8) ? 0 : 2)
         `CHK(n_we, 2)
         acc(2'd1, 1'b1);
         `CHK(rd_v, d)
         `CHK(n_oe, 2 * (k % 4 + 1))
         `CHK(n_sel, ((k / 4) % 2) ? n_oe : 2)
      end
      // Sync on clock B for divide codes 0, 1 and 2
      for (int n = 0; n < 3; n++)
      begin
         wr(8'h00, 32'(n));
         wr(8'h34, 32'h00000015);
         // Clock B period in core cycles, once the new code has settled
         @(posedge ckb);
         t = cyc;
         @(posedge ckb);
         `CHK(cyc - t, 2 << n)
         a = 20'(n); d = $urandom;
         acc(2'd1, 1'b0);
         acc(2'd1, 1'b1);
         `CHK(rd_v, d)
      end
      stop_test;
   end
endmodule
